//--- dv/tb.sv
module tb
  import uab_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock, i_srst, i_wr, i_rd, i_rx_done, i_rx_busy, serial_line;
  logic o_receive_flag, o_rx_hold_idle, o_wide_divisor_select, o_high_speed_select;
  logic [3:0] i_addr;
  logic [7:0] i_wdata, i_rx_data, o_rdata, rv;
  logic [15:0] o_rate_divisor;
  int miscompares = 0;
  int checked = 0;
  uab_autobaud_wake u_uab_autobaud_wake (.i_clock, .i_srst, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_serial_in_line(serial_line), .i_rx_data, .i_rx_done, .i_rx_busy,
    .o_receive_flag, .o_rx_hold_idle, .o_wide_divisor_select, .o_high_speed_select,
    .o_rate_divisor);
  uab_remote_node u_uab_remote_node (.i_clock, .o_line(serial_line));
  // ----------------------------------------
  // clock, tasks
  // ----------------------------------------
  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic give_verdict();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
    #1;
  endtask : wr_reg
  // read data stands only in the cycle after the taking edge
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : rd_reg
  // mode is {wide, high}; bit times chosen so the count fits the tick rate
  task automatic calibrate(input logic [1:0] mode, input logic wake, input int bit_clks);
    logic [15:0] ev;
    logic [15:0] old;
    ev = 16'h0001 + 16'(8 * bit_clks / (mode == 2'b11 ? 32 : mode == 2'b00 ? 512 : 128));
    old = o_rate_divisor;
    wr_reg(REG_RATE_CONTROL, {4'h0, mode[0], mode[1], wake, 1'b1});
    check("hold", o_rx_hold_idle, 1'b1);
    if (wake) begin
      u_uab_remote_node.send_break(bit_clks);
      check("wake flag", o_receive_flag, 1'b1);
      check("no count in break", o_rate_divisor, old);
      rd_reg(REG_RATE_CONTROL, rv);
      check("wake cleared", rv[BIT_WAKE_ENABLE], 1'b0);
      rd_reg(REG_RECEIVE_BUFFER, rv);
    end
    check("flag low", o_receive_flag, 1'b0);
    u_uab_remote_node.send_char(8'h55, bit_clks);
    check("divisor", o_rate_divisor, ev);
    check("cal flag", o_receive_flag, 1'b1);
    check("hold off", o_rx_hold_idle, 1'b0);
    rd_reg(REG_DIVISOR_HIGH, rv);
    check("divisor high", rv, ev[15:8]);
    rd_reg(REG_RATE_CONTROL, rv);
    check("enable cleared", rv[BIT_AUTOBAUD_ENABLE], 1'b0);
    rd_reg(REG_RECEIVE_BUFFER, rv);
    check("flag cleared", o_receive_flag, 1'b0);
    $display("calibration mode %b done", mode);
  endtask : calibrate
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    i_srst = 1'b1;
    i_addr = 4'h0;
    i_wdata = 8'h00;
    {i_wr, i_rd, i_rx_done, i_rx_busy} = 4'h0;
    i_rx_data = 8'h00;
    repeat (3) @(posedge i_clock);
    i_srst <= 1'b0;
    rd_reg(REG_RATE_CONTROL, rv);
    check("control reset", rv, RESET_RATE_CONTROL);
    check("divisor reset", o_rate_divisor, RESET_DIVISOR);
    wr_reg(REG_DIVISOR_LOW, 8'h67);
    rd_reg(REG_DIVISOR_LOW, rv);
    check("divisor low", rv, 8'h67);
    rd_reg(4'h9, rv);
    check("unmapped", rv, 8'h00);
    i_rx_busy <= 1'b1;
    rd_reg(REG_STATUS, rv);
    check("busy status", rv[BIT_RECEIVER_IDLE], 1'b0);
    i_rx_busy <= 1'b0;
    i_rx_data <= 8'h3c;
    i_rx_done <= 1'b1;
    @(posedge i_clock);
    i_rx_done <= 1'b0;
    @(posedge i_clock);
    check("rx flag", o_receive_flag, 1'b1);
    rd_reg(REG_RECEIVE_BUFFER, rv);
    check("rx byte", rv, 8'h3c);
    check("rx flag clear", o_receive_flag, 1'b0);
    $display("registers done");
    wr_reg(REG_RATE_CONTROL, 8'h02);
    fork
      u_uab_remote_node.send_break(256);
      begin
        repeat (8) @(posedge i_clock);
        check("wake flag", o_receive_flag, 1'b1);
        check("wake hold", o_rx_hold_idle, 1'b1);
      end
    join
    check("flag held", o_receive_flag, 1'b1);
    check("hold released", o_rx_hold_idle, 1'b0);
    rd_reg(REG_RECEIVE_BUFFER, rv);
    check("wake flag clear", o_receive_flag, 1'b0);
    wr_reg(REG_RATE_CONTROL, 8'h12);
    u_uab_remote_node.send_break(16);
    check("sync no wake", o_receive_flag, 1'b0);
    $display("wake done");
    wr_reg(REG_RATE_CONTROL, 8'h01);
    fork
      u_uab_remote_node.send_char(8'h55, 256);
      begin
        repeat (1200) @(posedge i_clock);
        rd_reg(REG_STATUS, rv);
        check("measuring", rv[BIT_MEASURE_ACTIVE], 1'b1);
        wr_reg(REG_RATE_CONTROL, 8'h00);
      end
    join
    check("abort flag", o_receive_flag, 1'b0);
    check("abort hold", o_rx_hold_idle, 1'b0);
    $display("abort done");
    for (int m = 0; m < 4; m++) begin
      calibrate(2'(m), m == 2, m == 3 ? 1088 : 256);
    end
    give_verdict();
  end
  // hang guard
  initial begin
    #400000;
    miscompares++;
    give_verdict();
  end
endmodule : tb

//--- dv/uab_checker.sv
module uab_checker
  import uab_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic i_serial_in_line,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_done,
  input wire logic i_rx_busy,
  input wire logic o_receive_flag,
  input wire logic o_rx_hold_idle,
  input wire logic o_wide_divisor_select,
  input wire logic o_high_speed_select,
  input wire logic [15:0] o_rate_divisor
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);
  logic [15:0] gap_ff;
  logic [15:0] cal_div;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // clocks since the divisor last moved; a wrong tick rate shows as a wrong gap
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      gap_ff <= 16'h0000;
    end else if ($changed(o_rate_divisor)) begin
      gap_ff <= 16'h0001;
    end else begin
      gap_ff <= gap_ff + 16'h0001;
    end
  end
  assign cal_div = (o_wide_divisor_select && o_high_speed_select) ? 16'h0020 :
      (o_wide_divisor_select || o_high_speed_select) ? 16'h0080 : 16'h0200;
  sequence ctl_write;
    i_wr && i_addr == REG_RATE_CONTROL;
  endsequence
  sequence count_move;
    $changed(o_rate_divisor) && !$past(i_wr);
  endsequence
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  ctl_hold_a: assert property (ctl_write |=> o_rx_hold_idle == ($past(i_wdata[0]) ||
      ($past(i_wdata[1]) && !$past(i_wdata[4])))) else $error("hold idle wrong after write");
  select_copy_a: assert property (ctl_write |=> o_wide_divisor_select == $past(i_wdata[2])
      && o_high_speed_select == $past(i_wdata[3])) else $error("select copies wrong");
  div_write_a: assert property (i_wr && i_addr == REG_DIVISOR_LOW && !o_rx_hold_idle
      |=> o_rate_divisor[7:0] == $past(i_wdata)) else $error("divisor low not written");
  div_step_a: assert property (count_move |-> o_rate_divisor == 16'h0001 ||
      o_rate_divisor == $past(o_rate_divisor) + 16'h0001) else $error("divisor bad step");
  step_gap_a: assert property (count_move ##0 o_rate_divisor != 16'h0001 |->
      gap_ff == cal_div) else $error("divisor step spacing wrong");
  read_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("read data not zero");
  unmapped_a: assert property (i_rd && i_addr > REG_STATUS |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  flag_clear_a: assert property ($fell(o_receive_flag) |-> $past(i_rd) &&
      $past(i_addr) == REG_RECEIVE_BUFFER) else $error("flag cleared without buffer read");
  flag_cause_a: assert property ($rose(o_receive_flag) |->
      $past(o_rx_hold_idle) || $past(i_rx_done)) else $error("flag set without cause");
endmodule : uab_checker

bind uab_autobaud_wake uab_checker u_uab_checker (.i_clock, .i_srst, .i_addr, .i_wdata,
  .i_wr, .i_rd, .o_rdata, .i_serial_in_line, .i_rx_data, .i_rx_done, .i_rx_busy,
  .o_receive_flag, .o_rx_hold_idle, .o_wide_divisor_select, .o_high_speed_select,
  .o_rate_divisor);

//--- dv/uab_remote_node.sv
module uab_remote_node (
  input wire logic i_clock,
  output logic o_line
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // remote node line driver, idle high
  // ----------------------------------------
  initial o_line = 1'b1;
  // one level held for a whole bit time
  task automatic put_bit(input logic level, input int clks);
    @(posedge i_clock);
    o_line <= level;
    repeat (clks - 1) @(posedge i_clock);
  endtask : put_bit
  // start bit, eight data bits lsb first, stop bit
  task automatic send_char(input logic [7:0] data, input int clks);
    put_bit(1'b0, clks);
    for (int i = 0; i < 8; i++) put_bit(data[i], clks);
    put_bit(1'b1, clks);
  endtask : send_char
  // wake break held low for thirteen bit times, then a quiet gap for the far end to settle
  task automatic send_break(input int clks);
    put_bit(1'b0, 13 * clks);
    put_bit(1'b1, 4 * clks);
  endtask : send_break
endmodule : uab_remote_node

//--- rtl/uab_autobaud_wake.sv
module uab_autobaud_wake
  import uab_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_serial_in_line,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_done,
  input wire logic i_rx_busy,
  output logic o_receive_flag,
  output logic o_rx_hold_idle,
  output logic o_wide_divisor_select,
  output logic o_high_speed_select,
  output logic [15:0] o_rate_divisor
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [1:0] rx_sync;
    logic rx_prev;
    uab_cal_state_type cal;
    logic [2:0] rises;
    logic autobaud_enable;
    logic wake_enable;
    logic wake_low;
    logic wide_divisor_select;
    logic high_speed_select;
    logic sync_select;
    logic [15:0] divisor;
    logic [7:0] buffer;
    logic receive_flag;
    logic [7:0] rdata;
    logic hold_idle;
  } uab_state_type;

  uab_state_type state_ff;
  uab_state_type nxt_state;
  uab_bus_req_type bus;
  logic cal_tick;
  logic [9:0] cal_divide;
  logic rx_level;
  logic rx_rise;
  logic rx_fall;
  logic wake_active;

  assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
  assign rx_level = state_ff.rx_sync[1];
  assign rx_rise = rx_level && !state_ff.rx_prev;
  assign rx_fall = !rx_level && state_ff.rx_prev;
  // wake monitor is ignored in synchronous mode
  assign wake_active = state_ff.wake_enable && !state_ff.sync_select;

  // ------------------------------------------------------------
  // calibration clock select
  // ------------------------------------------------------------
  always_comb begin
    unique case ({state_ff.wide_divisor_select, state_ff.high_speed_select})
      2'b00: cal_divide = CAL_DIV_SLOW;
      2'b11: cal_divide = CAL_DIV_FAST;
      default: cal_divide = CAL_DIV_MID;
    endcase
  end

  // divider restarts at the first rise so every period is whole
  uab_rate_tick u_cal_tick (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_clear(state_ff.cal != ST_COUNT),
    .i_divide(cal_divide),
    .o_tick(cal_tick)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_state.rx_sync = {state_ff.rx_sync[0], i_serial_in_line};
    nxt_state.rx_prev = rx_level;

    // receive buffer fed by the normal receiver when it runs
    if (i_rx_done && !state_ff.hold_idle) begin
      nxt_state.buffer = i_rx_data;
    end

    // register writes
    if (bus.wr) begin
      unique case (bus.addr)
        REG_RATE_CONTROL: begin
          nxt_state.autobaud_enable = bus.wdata[BIT_AUTOBAUD_ENABLE];
          nxt_state.wake_enable = bus.wdata[BIT_WAKE_ENABLE];
          nxt_state.wide_divisor_select = bus.wdata[BIT_WIDE_DIVISOR];
          nxt_state.high_speed_select = bus.wdata[BIT_HIGH_SPEED];
          nxt_state.sync_select = bus.wdata[BIT_SYNC_SELECT];
          if (bus.wdata[BIT_WAKE_ENABLE] && !state_ff.wake_enable) begin
            nxt_state.wake_low = 1'b0;
          end
        end
        REG_DIVISOR_LOW: nxt_state.divisor[7:0] = bus.wdata;
        REG_DIVISOR_HIGH: nxt_state.divisor[15:8] = bus.wdata;
        default: ;
      endcase
    end

    // receive buffer read clears the flag
    if (bus.rd && bus.addr == REG_RECEIVE_BUFFER) begin
      nxt_state.receive_flag = 1'b0;
    end
    if (i_rx_done && !state_ff.hold_idle) begin
      nxt_state.receive_flag = 1'b1; // set wins over clear
    end

    // wake monitor: any falling edge wakes, no low-time check
    if (wake_active) begin
      if (rx_fall && !state_ff.wake_low) begin
        nxt_state.wake_low = 1'b1;
        nxt_state.receive_flag = 1'b1;
      end else if (rx_rise && state_ff.wake_low) begin
        nxt_state.wake_enable = 1'b0;
        nxt_state.wake_low = 1'b0;
      end
    end

    // calibration sequence
    unique case (state_ff.cal)
      ST_IDLE: begin
        // waits while the break is still being watched
        if (state_ff.autobaud_enable && !wake_active) begin
          nxt_state.cal = ST_WAIT_START;
        end
      end
      ST_WAIT_START: begin
        if (rx_fall) begin
          nxt_state.cal = ST_WAIT_RISE;
        end
      end
      ST_WAIT_RISE: begin
        if (rx_rise) begin
          nxt_state.cal = ST_COUNT;
          nxt_state.divisor = CAL_COUNT_START;
          nxt_state.rises = 3'h1;
        end
      end
      ST_COUNT: begin
        if (cal_tick) begin
          nxt_state.divisor = state_ff.divisor + 16'h0001;
        end
        if (rx_rise) begin
          nxt_state.rises = state_ff.rises + 3'h1;
          if (state_ff.rises == 3'(CAL_RISING_EDGES - 1)) begin
            nxt_state.cal = ST_IDLE;
            nxt_state.autobaud_enable = 1'b0;
            nxt_state.receive_flag = 1'b1;
          end
        end
      end
      default: nxt_state.cal = ST_IDLE;
    endcase

    // software abort forces idle and masks any flag set in that cycle, but a tick in that cycle still steps the divisor
    if (state_ff.cal != ST_IDLE && !state_ff.autobaud_enable) begin
      nxt_state.cal = ST_IDLE;
      nxt_state.receive_flag = state_ff.receive_flag && nxt_state.receive_flag;
    end

    nxt_state.hold_idle = nxt_state.autobaud_enable || (nxt_state.wake_enable
                          && !nxt_state.sync_select);

    // read data, one cycle after the strobe
    nxt_state.rdata = 8'h00;
    if (bus.rd) begin
      unique case (bus.addr)
        REG_RATE_CONTROL: nxt_state.rdata = {3'h0, state_ff.sync_select,
          state_ff.high_speed_select, state_ff.wide_divisor_select,
          state_ff.wake_enable, state_ff.autobaud_enable};
        REG_DIVISOR_LOW: nxt_state.rdata = state_ff.divisor[7:0];
        REG_DIVISOR_HIGH: nxt_state.rdata = state_ff.divisor[15:8];
        REG_RECEIVE_BUFFER: nxt_state.rdata = state_ff.buffer;
        REG_STATUS: nxt_state.rdata = {5'h00, state_ff.cal != ST_IDLE,
          !i_rx_busy && state_ff.cal == ST_IDLE, state_ff.receive_flag};
        default: nxt_state.rdata = 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      state_ff <= '0;
      state_ff.rx_sync <= 2'h3;
      state_ff.rx_prev <= 1'b1;
      state_ff.cal <= ST_IDLE;
      state_ff.divisor <= RESET_DIVISOR;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_rdata = state_ff.rdata;
  assign o_receive_flag = state_ff.receive_flag;
  assign o_rx_hold_idle = state_ff.hold_idle;
  assign o_wide_divisor_select = state_ff.wide_divisor_select;
  assign o_high_speed_select = state_ff.high_speed_select;
  // outside rate generator divides by four times (divisor plus one) in fast 16-bit mode
  assign o_rate_divisor = state_ff.divisor;

endmodule : uab_autobaud_wake

//--- rtl/uab_pkg.sv
package uab_pkg;

  // ------------------------------------------------------------
  // register offsets (word index on the plain register port)
  // ------------------------------------------------------------
  localparam logic [3:0] REG_RATE_CONTROL = 4'h0;
  localparam logic [3:0] REG_DIVISOR_LOW = 4'h1;
  localparam logic [3:0] REG_DIVISOR_HIGH = 4'h2;
  localparam logic [3:0] REG_RECEIVE_BUFFER = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;

  // ------------------------------------------------------------
  // rate control field positions
  // ------------------------------------------------------------
  localparam int BIT_AUTOBAUD_ENABLE = 0;
  localparam int BIT_WAKE_ENABLE = 1;
  localparam int BIT_WIDE_DIVISOR = 2;
  localparam int BIT_HIGH_SPEED = 3;
  localparam int BIT_SYNC_SELECT = 4;

  // status field positions
  localparam int BIT_RECEIVE_FLAG = 0;
  localparam int BIT_RECEIVER_IDLE = 1;
  localparam int BIT_MEASURE_ACTIVE = 2;

  // ------------------------------------------------------------
  // reset values and counts
  // ------------------------------------------------------------
  localparam logic [7:0] RESET_RATE_CONTROL = 8'h00;
  localparam logic [15:0] RESET_DIVISOR = 16'h0000;
  localparam logic [15:0] CAL_COUNT_START = 16'h0001;
  localparam int CAL_RISING_EDGES = 5;
  // measurement clock dividers: base clock divided by 512, 128 or 32
  localparam logic [9:0] CAL_DIV_SLOW = 10'h200;
  localparam logic [9:0] CAL_DIV_MID = 10'h080;
  localparam logic [9:0] CAL_DIV_FAST = 10'h020;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WAIT_START = 4'h2,
    ST_WAIT_RISE = 4'h4,
    ST_COUNT = 4'h8
  } uab_cal_state_type;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } uab_bus_req_type;

endpackage : uab_pkg

//--- rtl/uab_rate_tick.sv
module uab_rate_tick
  import uab_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_clear,
  input wire logic [9:0] i_divide,
  output logic o_tick
);

  typedef struct packed {
    logic [9:0] count;
    logic tick;
  } uab_tick_state_type;

  uab_tick_state_type state_ff;
  uab_tick_state_type nxt_state;

  // ------------------------------------------------------------
  // divider: one pulse every i_divide clocks
  // ------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_state.tick = 1'b0;
    // restart at one: the registered pulse then lands a whole period after the clear
    if (i_clear) begin
      nxt_state.count = 10'h001;
    end else if (state_ff.count >= i_divide - 10'h001) begin
      nxt_state.count = 10'h000;
      nxt_state.tick = 1'b1;
    end else begin
      nxt_state.count = state_ff.count + 10'h001;
    end
  end

  // state register
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_tick = state_ff.tick;

endmodule : uab_rate_tick
